/* File: pvcs_pkg.sv */
// ****************************************************************
// constants of the per-virtual-processor config and schedule bank
// ****************************************************************
package pvcs_pkg;
  // coprocessor register number and selects of this bank
  localparam logic [4:0] PVCS_COP_REG = 5'h01;
  localparam logic [2:0] PVCS_SEL_COP_RES = 3'h3; // coprocessor_resource_config
  localparam logic [2:0] PVCS_SEL_QMASK = 3'h4; // suspend_qualifier_mask
  localparam logic [2:0] PVCS_SEL_HINT = 3'h5; // scheduler_hint
  localparam logic [2:0] PVCS_SEL_FBACK = 3'h6; // scheduler_feedback
  localparam logic [2:0] PVCS_SEL_WAYOPT = 3'h7; // cache_way_options
  // coprocessor_resource_config field positions
  localparam int PVCS_UDI_LSB = 20; // udi_context_count 27:20
  localparam int PVCS_COP2_LSB = 10; // cop_two_context_count 17:10
  localparam int PVCS_COP1_LSB = 0; // cop_one_context_count 7:0
  localparam int PVCS_CNT_W = 8;
  localparam logic [31:0] PVCS_COP_RES_WMASK = 32'h0ff3fcff; // writable fields
  localparam logic [31:0] PVCS_COP_RES_RSVD = 32'hf00c0300; // reads as zero
  // suspend_qualifier_mask layout
  localparam int PVCS_QMASK_W = 31; // bits 30:0, bit 31 reads zero
  localparam logic [30:0] PVCS_QMASK_RESET = 31'h00000000;
  // cache_way_options layout
  localparam int PVCS_DWX_LSB = 0; // dcache_way_exclusion_mask 7:0
  localparam int PVCS_IWX_LSB = 8; // icache_way_exclusion_mask 15:8
  localparam int PVCS_WAYS = 8;
  localparam logic [15:0] PVCS_WAYOPT_RESET = 16'h0000;
  // scheduler hint and feedback reset values
  localparam logic [31:0] PVCS_HINT_RESET = 32'h00000000;
  localparam logic [31:0] PVCS_FBACK_RESET = 32'h00000000;
  // hint bits used as a weight, and cycles of the read path
  localparam int PVCS_WEIGHT_W = 4;
  localparam int PVCS_RD_LATENCY = 2;
  // exception_cause_field value for an illegal qualifier
  localparam int PVCS_EXC_W = 3;
  localparam logic [2:0] PVCS_EXC_BAD_QUAL = 3'h3;
  // scheduler states, gray along fetch -> grant
  typedef enum logic [1:0] {
    PVCS_SCH_IDLE = 2'b00,
    PVCS_SCH_FETCH = 2'b01,
    PVCS_SCH_GRANT = 2'b11
  } pvcs_sch_t;
endpackage : pvcs_pkg

/* File: pvcs_mem_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// carrier between the bank and its hint memory
// ****************************************************************
interface pvcs_mem_if #(parameter int WIDTH = 32, parameter int AW = 1);
  logic we; // write strobe
  logic [AW-1:0] waddr; // word written
  logic [WIDTH-1:0] wdata; // data written
  logic [AW-1:0] ra_addr; // software read port
  logic [WIDTH-1:0] ra_data;
  logic [AW-1:0] rb_addr; // scheduler read port
  logic [WIDTH-1:0] rb_data;
  modport ctrl (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
  modport mem (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
endinterface : pvcs_mem_if

/* File: pvcs_hint_mem.sv */
`timescale 1ns/1ps
// ****************************************************************
// per-virtual-processor hint words, registered read ports
// ****************************************************************
module pvcs_hint_mem
  import pvcs_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int WIDTH = 32
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  pvcs_mem_if.mem bus
);
  logic [WIDTH-1:0] words [DEPTH]; // one word per virtual processor

  // write port; reset clears all words so hint zero is the default
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= WIDTH'(PVCS_HINT_RESET);
      end
    end else if (bus.we) begin
      words[bus.waddr] <= bus.wdata;
    end
  end

  // both reads come out of a register, one cycle after the address
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus.ra_data <= '0;
      bus.rb_data <= '0;
    end else begin
      bus.ra_data <= words[bus.ra_addr];
      bus.rb_data <= words[bus.rb_addr];
    end
  end
endmodule : pvcs_hint_mem

/* File: pvcs_regs.sv */
`timescale 1ns/1ps
// Operation
// RULE1 - resource register writable only under config permission
// RULE2 - bits 27:20 give preset udi context count
// RULE3 - bits 17:10 give second coprocessor contexts
// RULE4 - bits 7:0 give first coprocessor contexts
// RULE5 - resource reserved bits read zero, written zero
// RULE6 - qualifier mask 30:0 read-write, resets zero
// RULE7 - qualifier mask bit 31 reads zero
// RULE8 - illegal suspend qualifier raises exception cause 3
// RULE9 - unimplemented qualifier mask bits hard-wired zero
// RULE10 - hint zero gives well-behaved default scheduling
// RULE11 - two-level bandwidth: processor share, then threads
// RULE12 - feedback counts retired instructions until cleared
// RULE13 - bits 15:8 instruction way exclusion, when enabled
// RULE14 - partitioning capability field marks exclusion fields
// RULE15 - every virtual processor has own register copies
// RULE16 - set instruction bit blocks that way allocation
// RULE17 - bits 7:0 data way exclusion mask
// RULE18 - way options bits 31:16 read zero
// RULE19 - locked resource register writes are ignored
module pvcs_regs
  import pvcs_pkg::*;
#(
  parameter int NUM_VPE = 2,
  parameter int QUAL_INPUTS = 31,
  parameter logic [7:0] UDI_CONTEXTS = 8'h01,
  parameter logic [7:0] COP2_CONTEXTS = 8'h00,
  parameter logic [7:0] COP1_CONTEXTS = 8'h01,
  parameter bit PARTITION_CAP = 1'b1,
  localparam int VW = (NUM_VPE > 1) ? $clog2(NUM_VPE) : 1
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic cop_wr_in,
  input wire logic cop_rd_in,
  input wire logic [4:0] cop_reg_in,
  input wire logic [2:0] cop_sel_in,
  input wire logic [VW-1:0] cop_vpe_in,
  input wire logic [31:0] cop_wdata_in,
  output logic [31:0] cop_rdata_out,
  output logic cop_rvalid_out,
  input wire logic config_permission_bit_in,
  input wire logic partition_enable_in,
  output logic partitioning_capability_field_out,
  input wire logic thread_suspend_instruction_valid_in,
  input wire logic [VW-1:0] thread_suspend_instruction_vpe_in,
  input wire logic [31:0] source_operand_in,
  output logic thread_suspend_instruction_exc_out,
  output logic [PVCS_EXC_W-1:0] exception_cause_field_out,
  input wire logic [NUM_VPE-1:0] vpe_ready_in,
  output logic issue_valid_out,
  output logic [VW-1:0] issue_vpe_out,
  input wire logic retire_valid_in,
  input wire logic [VW-1:0] retire_vpe_in,
  input wire logic alloc_valid_in,
  input wire logic [VW-1:0] alloc_vpe_in,
  output logic [PVCS_WAYS-1:0] icache_way_allowed_out,
  output logic [PVCS_WAYS-1:0] dcache_way_allowed_out
);
  // ****************************************************************
  // parameter checks and constants
  // ****************************************************************
  if (NUM_VPE < 2 || QUAL_INPUTS < 1 || QUAL_INPUTS > PVCS_QMASK_W) begin : g_bad_param
    $error("pvcs_regs: unsupported NUM_VPE or QUAL_INPUTS");
  end
  // implemented qualifier inputs; the rest of the mask stays zero
  localparam logic [30:0] QMASK_IMPL = 31'((64'h1 << QUAL_INPUTS) - 64'h1);

  // allowed ways: excluded ways masked only when partitioning is live
  function automatic logic [PVCS_WAYS-1:0] way_allow(input logic [PVCS_WAYS-1:0] excl, input logic live);
    way_allow = live ? ~excl : {PVCS_WAYS{1'b1}};
  endfunction : way_allow

  // ****************************************************************
  // per-virtual-processor state
  // ****************************************************************
  logic [31:0] cop_res [NUM_VPE]; // resource counts, preset
  logic [30:0] qmask [NUM_VPE]; // suspend_qualifier_mask
  logic [31:0] fback [NUM_VPE]; // scheduler_feedback
  logic [15:0] wayopt [NUM_VPE]; // cache_way_options low half
  logic hit; // bank is addressed
  logic rd_p1; // read stage one
  logic [2:0] rd_sel_p1;
  logic [VW-1:0] rd_vpe_p1;
  logic [2:0] rd_sel_out; // select of the word on cop_rdata_out
  pvcs_sch_t sch_state;
  logic [VW-1:0] sch_vpe; // virtual processor being served
  logic [VW-1:0] next_sch_vpe; // processor served after this edge
  logic [PVCS_WEIGHT_W:0] credit; // issue slots left in its share
  logic thread_suspend_instruction_bad; // operand names an unmasked qualifier
  pvcs_mem_if #(.WIDTH(32), .AW(VW)) hint_bus ();

  assign hit = (cop_reg_in == PVCS_COP_REG);

  // hint words live in their own memory
  pvcs_hint_mem #(.DEPTH(NUM_VPE), .WIDTH(32)) u_hint_mem (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .bus(hint_bus.mem)
  );
  assign hint_bus.we = cop_wr_in && hit && (cop_sel_in == PVCS_SEL_HINT); // RULE10
  assign hint_bus.waddr = cop_vpe_in;
  assign hint_bus.wdata = cop_wdata_in;
  assign hint_bus.ra_addr = cop_vpe_in;
  // registered read needs the next processor's address a cycle early,
  // otherwise fetch would load the hint of the processor just left
  assign next_sch_vpe = (sch_state == PVCS_SCH_GRANT && !(vpe_ready_in[sch_vpe] && credit != '0))
                        ? ((sch_vpe == VW'(NUM_VPE - 1)) ? '0 : sch_vpe + 1'b1) : sch_vpe;
  assign hint_bus.rb_addr = next_sch_vpe; // RULE15

  // ****************************************************************
  // software writes
  // ****************************************************************
  // resource counts: preset at reset, changed only with permission
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_VPE; i++) begin
        cop_res[i] <= {4'h0, UDI_CONTEXTS, 2'b00, COP2_CONTEXTS, 2'b00, COP1_CONTEXTS}; // RULE2 RULE3 RULE4 RULE15
      end
    end else if (cop_wr_in && hit && cop_sel_in == PVCS_SEL_COP_RES && config_permission_bit_in) begin // RULE1 RULE19
      cop_res[cop_vpe_in] <= cop_wdata_in & PVCS_COP_RES_WMASK; // RULE5
    end
  end

  // qualifier mask; unimplemented inputs never stored
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_VPE; i++) begin
        qmask[i] <= PVCS_QMASK_RESET; // RULE6 RULE15
      end
    end else if (cop_wr_in && hit && cop_sel_in == PVCS_SEL_QMASK) begin
      qmask[cop_vpe_in] <= cop_wdata_in[30:0] & QMASK_IMPL; // RULE6 RULE9
    end
  end

  // way exclusion masks; upper half is not stored at all
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_VPE; i++) begin
        wayopt[i] <= PVCS_WAYOPT_RESET;
      end
    end else if (cop_wr_in && hit && cop_sel_in == PVCS_SEL_WAYOPT) begin
      wayopt[cop_vpe_in] <= cop_wdata_in[15:0]; // RULE13 RULE17 RULE18
    end
  end

  // feedback: retire count; a retire in the write cycle is kept
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_VPE; i++) begin
        fback[i] <= PVCS_FBACK_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_VPE; i++) begin
        if (cop_wr_in && hit && cop_sel_in == PVCS_SEL_FBACK && cop_vpe_in == VW'(i)) begin
          fback[i] <= cop_wdata_in + {31'h0, retire_valid_in && retire_vpe_in == VW'(i)}; // RULE12
        end else if (retire_valid_in && retire_vpe_in == VW'(i)) begin
          fback[i] <= fback[i] + 32'h1; // RULE12
        end
      end
    end
  end

  // ****************************************************************
  // read path: two cycles; the first stage matches the one-cycle hint memory latency
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_p1 <= 1'b0;
      rd_sel_p1 <= 3'h0;
      rd_vpe_p1 <= '0;
    end else begin
      rd_p1 <= cop_rd_in;
      rd_sel_p1 <= hit ? cop_sel_in : 3'h0; // other registers read zero
      rd_vpe_p1 <= cop_vpe_in;
    end
  end

  // second stage composes the word
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cop_rvalid_out <= 1'b0;
      cop_rdata_out <= 32'h0;
      rd_sel_out <= 3'h0;
    end else begin
      cop_rvalid_out <= rd_p1;
      rd_sel_out <= rd_sel_p1;
      case (rd_sel_p1)
        PVCS_SEL_COP_RES: cop_rdata_out <= cop_res[rd_vpe_p1] & ~PVCS_COP_RES_RSVD; // RULE5
        PVCS_SEL_QMASK: cop_rdata_out <= {1'b0, qmask[rd_vpe_p1]}; // RULE7
        PVCS_SEL_HINT: cop_rdata_out <= hint_bus.ra_data;
        PVCS_SEL_FBACK: cop_rdata_out <= fback[rd_vpe_p1];
        PVCS_SEL_WAYOPT: cop_rdata_out <= {16'h0, wayopt[rd_vpe_p1]}; // RULE18
        default: cop_rdata_out <= 32'h0; // unmapped select
      endcase
    end
  end

  // ****************************************************************
  // suspend qualifier check
  // ****************************************************************
  assign thread_suspend_instruction_bad = !source_operand_in[31] && (source_operand_in != 32'h0)
                     && ((source_operand_in[30:0] & ~qmask[thread_suspend_instruction_vpe_in]) != 31'h0); // RULE8

  // exception pulse with its cause code
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      thread_suspend_instruction_exc_out <= 1'b0;
      exception_cause_field_out <= '0;
    end else begin
      thread_suspend_instruction_exc_out <= thread_suspend_instruction_valid_in && thread_suspend_instruction_bad; // RULE8
      if (thread_suspend_instruction_valid_in && thread_suspend_instruction_bad) begin
        exception_cause_field_out <= PVCS_EXC_BAD_QUAL; // RULE8
      end
    end
  end

  // ****************************************************************
  // scheduler: hint weight gives a processor its share of slots
  // ****************************************************************
  // thread selection happens downstream inside the granted share,
  // so thread hints only split what this level hands out
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sch_state <= PVCS_SCH_IDLE;
      sch_vpe <= '0;
      credit <= '0;
      issue_valid_out <= 1'b0;
      issue_vpe_out <= '0;
    end else begin
      issue_valid_out <= 1'b0;
      case (sch_state)
        PVCS_SCH_IDLE: begin
          sch_state <= PVCS_SCH_FETCH;
        end
        PVCS_SCH_FETCH: begin
          // hint zero gives weight one: equal round robin by default
          credit <= {1'b0, hint_bus.rb_data[PVCS_WEIGHT_W-1:0]} + 1'b1; // RULE10 RULE11
          sch_state <= PVCS_SCH_GRANT;
        end
        PVCS_SCH_GRANT: begin
          if (vpe_ready_in[sch_vpe] && credit != '0) begin
            issue_valid_out <= 1'b1; // RULE11
            issue_vpe_out <= sch_vpe;
            credit <= credit - 1'b1;
          end else begin
            // idle or exhausted processor gives up its turn
            sch_vpe <= next_sch_vpe;
            sch_state <= PVCS_SCH_FETCH;
          end
        end
        default: sch_state <= PVCS_SCH_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // cache allocation gates
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      icache_way_allowed_out <= {PVCS_WAYS{1'b1}};
      dcache_way_allowed_out <= {PVCS_WAYS{1'b1}};
      partitioning_capability_field_out <= 1'b0;
    end else begin
      partitioning_capability_field_out <= PARTITION_CAP; // RULE14
      if (alloc_valid_in) begin
        icache_way_allowed_out <= way_allow(wayopt[alloc_vpe_in][15:8], PARTITION_CAP && partition_enable_in); // RULE13 RULE16
        dcache_way_allowed_out <= way_allow(wayopt[alloc_vpe_in][7:0], PARTITION_CAP && partition_enable_in); // RULE17
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0] cop_res_sel; // resource word being addressed
  logic [VW-1:0] chk_vpe; // address of the previous cycle
  logic [31:0] cop_res_prev;
  assign cop_res_sel = cop_res[cop_vpe_in];
  assign cop_res_prev = cop_res[chk_vpe];
  always_ff @(posedge mclk_in) begin
    chk_vpe <= cop_vpe_in;
  end

  sequence s_fetch;
    sch_state == PVCS_SCH_FETCH;
  endsequence
  sequence s_grant;
    sch_state == PVCS_SCH_GRANT;
  endsequence

  property p_cop_locked;
    @(posedge mclk_in) disable iff (reset_in)
    (cop_wr_in && hit && cop_sel_in == PVCS_SEL_COP_RES && !config_permission_bit_in)
    |=> cop_res_prev == $past(cop_res_sel);
  endproperty
  a_cop_locked: assert property (p_cop_locked) else $error("locked resource word changed"); // RULE19
  property p_cop_rsvd;
    @(posedge mclk_in) disable iff (reset_in)
    (cop_rvalid_out && rd_sel_out == PVCS_SEL_COP_RES) |-> (cop_rdata_out & PVCS_COP_RES_RSVD) == 32'h0;
  endproperty
  a_cop_rsvd: assert property (p_cop_rsvd) else $error("resource reserved bits set"); // RULE5
  property p_qmask_top;
    @(posedge mclk_in) disable iff (reset_in)
    (cop_rvalid_out && rd_sel_out == PVCS_SEL_QMASK) |-> !cop_rdata_out[31];
  endproperty
  a_qmask_top: assert property (p_qmask_top) else $error("qualifier mask bit 31 set"); // RULE7
  property p_qmask_impl;
    @(posedge mclk_in) disable iff (reset_in)
    (qmask[cop_vpe_in] & ~QMASK_IMPL) == 31'h0;
  endproperty
  a_qmask_impl: assert property (p_qmask_impl) else $error("unimplemented qualifier bit set"); // RULE9
  property p_thread_suspend_instruction_exc;
    @(posedge mclk_in) disable iff (reset_in)
    (thread_suspend_instruction_valid_in && thread_suspend_instruction_bad) |=> thread_suspend_instruction_exc_out && exception_cause_field_out == PVCS_EXC_BAD_QUAL;
  endproperty
  a_thread_suspend_instruction_exc: assert property (p_thread_suspend_instruction_exc) else $error("illegal qualifier not trapped"); // RULE8
  property p_thread_suspend_instruction_ok;
    @(posedge mclk_in) disable iff (reset_in)
    !(thread_suspend_instruction_valid_in && thread_suspend_instruction_bad) |=> !thread_suspend_instruction_exc_out;
  endproperty
  a_thread_suspend_instruction_ok: assert property (p_thread_suspend_instruction_ok) else $error("spurious qualifier exception"); // RULE8
  property p_wayopt_hi;
    @(posedge mclk_in) disable iff (reset_in)
    (cop_rvalid_out && rd_sel_out == PVCS_SEL_WAYOPT) |-> cop_rdata_out[31:16] == 16'h0;
  endproperty
  a_wayopt_hi: assert property (p_wayopt_hi) else $error("way options upper half set"); // RULE18
  property p_sched_step;
    @(posedge mclk_in) disable iff (reset_in)
    s_fetch |=> s_grant;
  endproperty
  a_sched_step: assert property (p_sched_step) else $error("scheduler skipped grant"); // RULE11
  property p_rd_lat;
    @(posedge mclk_in) disable iff (reset_in)
    cop_rd_in |-> ##2 cop_rvalid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late"); // RULE15
endmodule : pvcs_regs

/* File: pvcs_far_model.sv */
`timescale 1ns/1ps
// ****************
// far side: pipeline that retires each granted issue slot
// ****************
module pvcs_far_model (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [1:0] ready_mask_in, // bench chooses who has work
  input wire logic issue_valid_in,
  input wire logic issue_vpe_in,
  output logic [1:0] vpe_ready_out,
  output logic retire_valid_out,
  output logic retire_vpe_out
);
  // ready is a plain level per processor
  assign vpe_ready_out = ready_mask_in;
  // every granted slot retires one cycle later, so feedback can be predicted
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      retire_valid_out <= 1'b0;
      retire_vpe_out <= 1'b0;
    end else begin
      retire_valid_out <= issue_valid_in;
      // idle index line toggles so a stale value is never mistaken for a retire
      retire_vpe_out <= issue_valid_in ? issue_vpe_in : ~retire_vpe_out;
    end
  end
endmodule : pvcs_far_model

/* File: per_vpe_config_sched_regs_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
// ****************
// bench of the per-processor config and schedule bank
// ****************
module per_vpe_config_sched_regs_bench;
  typedef struct packed {
    logic [2:0] sel;
    logic vpe;
    logic perm;
    logic [31:0] wd;
    logic [31:0] ex;
  } pvcs_row_t;
  logic mclk_in, reset_in, cop_wr, cop_rd, cop_vpe, rvalid, perm, pen, cap;
  logic yv, yvpe, yexc, iv, ivpe, rv, rvpe, av, avpe;
  logic [4:0] cop_reg;
  logic [2:0] cop_sel, cause;
  logic [31:0] cop_wdata, rdata, opnd;
  logic [1:0] ready, rmask;
  logic [7:0] iw, dw;
  int mismatches = 0;
  int checks_done = 0;
  int cnt0 = 0; // slots seen per processor
  int cnt1 = 0;
  // write then read back; resource reserved bits written zero, locked fields as ones then zeros
  pvcs_row_t rows [11] = '{
    '{3'h3, 1'b0, 1'b0, 32'h0ff3fcff, 32'h00100001},
    '{3'h3, 1'b0, 1'b1, 32'h0ff3fcff, 32'h0ff3fcff},
    '{3'h3, 1'b1, 1'b0, 32'h00000000, 32'h00100001},
    '{3'h3, 1'b1, 1'b1, 32'h00000000, 32'h00000000},
    '{3'h4, 1'b0, 1'b0, 32'h7fffffff, 32'h00ffffff},
    '{3'h4, 1'b1, 1'b0, 32'h0000000f, 32'h0000000f},
    '{3'h5, 1'b0, 1'b0, 32'h00000003, 32'h00000003},
    '{3'h6, 1'b1, 1'b0, 32'h00000040, 32'h00000040},
    '{3'h7, 1'b0, 1'b0, 32'hffff5a3c, 32'h00005a3c},
    '{3'h7, 1'b1, 1'b0, 32'h0000ff00, 32'h0000ff00},
    '{3'h2, 1'b0, 1'b0, 32'h12345678, 32'h00000000}};
  // ****************
  // design and far side
  // ****************
  pvcs_regs #(.NUM_VPE(2), .QUAL_INPUTS(24)) uut (.mclk_in(mclk_in), .reset_in(reset_in),
    .cop_wr_in(cop_wr), .cop_rd_in(cop_rd), .cop_reg_in(cop_reg), .cop_sel_in(cop_sel),
    .cop_vpe_in(cop_vpe), .cop_wdata_in(cop_wdata), .cop_rdata_out(rdata), .cop_rvalid_out(rvalid),
    .config_permission_bit_in(perm), .partition_enable_in(pen), .partitioning_capability_field_out(cap),
    .thread_suspend_instruction_valid_in(yv), .thread_suspend_instruction_vpe_in(yvpe), .source_operand_in(opnd), .thread_suspend_instruction_exc_out(yexc),
    .exception_cause_field_out(cause), .vpe_ready_in(ready), .issue_valid_out(iv), .issue_vpe_out(ivpe),
    .retire_valid_in(rv), .retire_vpe_in(rvpe), .alloc_valid_in(av), .alloc_vpe_in(avpe),
    .icache_way_allowed_out(iw), .dcache_way_allowed_out(dw));
  pvcs_far_model far (.mclk_in(mclk_in), .reset_in(reset_in), .ready_mask_in(rmask), .issue_valid_in(iv),
    .issue_vpe_in(ivpe), .vpe_ready_out(ready), .retire_valid_out(rv), .retire_vpe_out(rvpe));
  // ****************
  // clock, slot monitor, watchdog
  // ****************
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // values sampled here are those launched at the previous edge
  always @(posedge mclk_in) begin
    if (!reset_in && iv === 1'b1) begin
      if (ivpe === 1'b0) cnt0++;
      else cnt1++;
    end
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk_in);
    mismatches++;
    final_report();
  end
  // ****************
  // bus tasks
  // ****************
  task automatic wr(input logic [2:0] sel, input logic vpe, input logic pm, input logic [31:0] d);
    @(negedge mclk_in);
    cop_sel = sel;
    cop_vpe = vpe;
    cop_wdata = d;
    perm = pm;
    cop_wr = 1'b1;
    @(negedge mclk_in);
    cop_wr = 1'b0;
    perm = 1'b0;
  endtask : wr
  // answer is launched by the edge after the taking edge and stands one cycle
  task automatic rd(input logic [2:0] sel, input logic vpe, input logic [31:0] exp);
    @(negedge mclk_in);
    cop_sel = sel;
    cop_vpe = vpe;
    cop_rd = 1'b1;
    @(negedge mclk_in);
    cop_rd = 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, exp)
  endtask : rd
  task automatic ychk(input logic vpe, input logic [31:0] op, input logic exp);
    @(negedge mclk_in);
    yvpe = vpe;
    opnd = op;
    yv = 1'b1;
    @(negedge mclk_in);
    yv = 1'b0;
    // exception pulse stands only until the next edge, so look now
    `CHK(yexc, exp)
    if (exp) `CHK(cause, 3'h3)
  endtask : ychk
  task automatic achk(input logic vpe, input logic en, input logic [7:0] ei, input logic [7:0] ed);
    @(negedge mclk_in);
    avpe = vpe;
    pen = en;
    av = 1'b1;
    @(negedge mclk_in);
    av = 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(iw, ei)
    `CHK(dw, ed)
  endtask : achk
  task automatic final_report();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ****************
  // main sequence
  // ****************
  initial begin
    {reset_in, cop_wr, cop_rd, cop_vpe, perm, pen, yv, yvpe, av, avpe} = 10'h200;
    cop_reg = 5'h01;
    cop_sel = 3'h0;
    cop_wdata = 32'h0;
    opnd = 32'h0;
    rmask = 2'b00; // no work, so no retires disturb feedback
    repeat (10) @(negedge mclk_in);
    reset_in = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].vpe, rows[i].perm, rows[i].wd);
      rd(rows[i].sel, rows[i].vpe, rows[i].ex);
    end
    // suspend qualifier checks against each processor's mask
    ychk(1'b1, 32'h00000010, 1'b1);
    ychk(1'b1, 32'h0000000c, 1'b0);
    ychk(1'b1, 32'h80000010, 1'b0);
    ychk(1'b0, 32'h01000000, 1'b1);
    ychk(1'b0, 32'h00800000, 1'b0);
    // allocation masks, partitioning on then off
    achk(1'b0, 1'b1, 8'ha5, 8'hc3);
    achk(1'b1, 1'b1, 8'h00, 8'hff);
    achk(1'b0, 1'b0, 8'hff, 8'hff);
    `CHK(cap, 1'b1)
    // hint 3 on processor 0 against hint 0 on processor 1
    @(negedge mclk_in);
    rmask = 2'b11;
    for (int k = 0; k < 400 && cnt1 < 5; k++) @(negedge mclk_in);
    `CHK((cnt0 == 16) || (cnt0 == 20), 1'b1)
    rmask = 2'b00;
    repeat (10) @(negedge mclk_in);
    rd(3'h6, 1'b0, 32'(cnt0));
    rd(3'h6, 1'b1, 32'h40 + 32'(cnt1));
    // second reset in mid-run restores every word
    @(negedge mclk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    `CHK(iw, 8'hff)
    `CHK(rvalid, 1'b0)
    reset_in = 1'b0;
    rd(3'h3, 1'b1, 32'h00100001);
    rd(3'h4, 1'b1, 32'h0);
    rd(3'h5, 1'b0, 32'h0);
    rd(3'h6, 1'b1, 32'h0);
    rd(3'h7, 1'b0, 32'h0);
    final_report();
  end
endmodule : per_vpe_config_sched_regs_bench
